/* File: feed_io_pkg.sv */
`default_nettype none

package feed_io_pkg;

	// ---------------------------------------------------------------
	// Group scan sequence
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {grp_a, grp_b, grp_c, grp_d} group_e;

	// Two-bit motor codes, written as {bit1, bit0}.
	localparam logic [1:0] PED_MOTOR_BRAKE = 2'h0;
	localparam logic [1:0] PED_MOTOR_ON = 2'h1;
	localparam logic [1:0] PED_MOTOR_OFF = 2'h3;
	localparam logic [1:0] TRAY_OFF = 2'h0;
	localparam logic [1:0] TRAY_UP = 2'h1;
	localparam logic [1:0] TRAY_DOWN = 2'h2;
	localparam logic [1:0] TRAY_BRAKE = 2'h3;

	// Settle time after an enable goes low, before the buses are sampled.
	localparam int SETTLE_NS = 400;
	localparam int CLK_NS = 100;
	localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
	// Drive bus setup time before a strobe rises, and strobe high width.
	localparam int SETUP_NS = 200;
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] STROBE_CYC = 4'h2;
	// Reference clock half period for the main motor, in mclk cycles.
	localparam logic [7:0] REF_HALF_CYC = 8'h19;

	// Exit option codes reported from return bits {7,4,1}.
	typedef enum logic [1:0] {exit_none, exit_separator, exit_bridge, exit_offset} exit_e;

	// Bus value before the first load. The latches ignore it until a strobe rises.
	localparam logic [7:0] DRIVE_IDLE = 8'h00;

endpackage : feed_io_pkg

`default_nettype wire

/* File: strobe_drive.sv */
`timescale 1ns/10ps
`default_nettype none

// Sequences one drive byte onto the shared bus and pulses one of the two
// feeder strobes after the setup time.
module strobe_drive
	import feed_io_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Request side
	input wire logic req_valid,
	input wire logic req_second,
	input wire logic [7:0] req_data,
	output logic req_ready,
	// Pins
	output logic [7:0] drive_output_bus,
	output logic first_feeder_strobe,
	output logic second_feeder_strobe
);

	typedef enum logic [1:0] {st_idle, st_setup, st_high} st_e;

	typedef struct packed {
		st_e st;
		logic [3:0] cnt;
		logic sel;
		logic [7:0] bus;
		logic s1;
		logic s2;
	} state_s;

	state_s q, d;

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	// Data is placed first and held through the strobe so the latch sees a
	// stable byte on its rising edge.
	always_comb begin
		d = q;
		case (q.st)
			st_idle: begin
				if (req_valid) begin
					d.bus = req_data;
					d.sel = req_second;
					d.cnt = SETUP_CYC;
					d.st = st_setup;
				end
			end
			st_setup: begin
				if (q.cnt > 4'h1) begin
					d.cnt = q.cnt - 4'h1;
				end else begin
					d.s1 = ~q.sel;
					d.s2 = q.sel;
					d.cnt = STROBE_CYC;
					d.st = st_high;
				end
			end
			st_high: begin
				if (q.cnt > 4'h1) begin
					d.cnt = q.cnt - 4'h1;
				end else begin
					d.s1 = 1'b0;
					d.s2 = 1'b0;
					d.st = st_idle;
				end
			end
			default: d.st = st_idle;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{st: st_idle, cnt: 4'h0, sel: 1'b0, bus: DRIVE_IDLE, s1: 1'b0, s2: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign req_ready = (q.st == st_idle);
	assign drive_output_bus = q.bus;
	assign first_feeder_strobe = q.s1;
	assign second_feeder_strobe = q.s2;

endmodule : strobe_drive

`default_nettype wire

/* File: paper_feed_multiplexed_io.sv */
`timescale 1ns/10ps
`default_nettype none

module paper_feed_multiplexed_io
	import feed_io_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Sensor buses from the buffers and their group enables
	input wire logic [3:0] size_input_bus,
	input wire logic [7:0] return_input_bus,
	output logic group_a_enable_n,
	output logic group_b_enable_n,
	output logic group_c_enable_n,
	output logic group_d_enable_n,
	// Feeder type: high for large capacity, low for pedestal
	input wire logic large_capacity_feeder,
	// Pedestal feeder commands
	input wire logic [1:0] ped_motor,
	input wire logic ped_upper_clutch,
	input wire logic ped_lower_clutch,
	input wire logic ped_transport_clutch,
	input wire logic [1:0] ped_upper_tray,
	input wire logic [1:0] ped_lower_tray,
	// Large capacity feeder commands
	input wire logic bulk_motor_on,
	input wire logic bulk_low_speed,
	input wire logic bulk_transport_clutch,
	input wire logic bulk_feed_clutch,
	input wire logic bulk_pickup,
	input wire logic [1:0] bulk_tray,
	input wire logic [1:0] bulk_fence_motor,
	input wire logic bulk_fence_solenoid,
	// Drive bus and strobes
	output logic [7:0] drive_output_bus,
	output logic first_feeder_strobe,
	output logic second_feeder_strobe,
	// Decoded sensor state
	output logic [2:0] bypass_width,
	output logic ped_upper_drawer_open,
	output logic ped_lower_drawer_open,
	output logic duplex_entry_paper,
	output logic duplex_exit_paper,
	output logic duplex_open,
	output logic duplex_connected,
	output logic [7:0] ret_group_a,
	output logic [7:0] ret_group_b,
	output logic [7:0] ret_group_c,
	output logic [7:0] ret_group_d,
	output logic [1:0] exit_option,
	// Transport clutch
	input wire logic upper_transport_request,
	input wire logic middle_transport_request,
	output logic upper_transport_clutch_n,
	// Main motor reference
	input wire logic main_motor_run,
	output logic main_motor_ref_clock,
	// External selects
	input wire logic nvmem_access,
	input wire logic nvmem_write,
	input wire logic finisher_access,
	output logic nvmem_select_n,
	output logic nvmem_write_en_n,
	output logic finisher_select_n
);

	typedef struct packed {
		logic [3:0] sz1;
		logic [3:0] sz2;
		logic [7:0] rt1;
		logic [7:0] rt2;
		logic [1:0] rq1;
		logic [1:0] rq2;
		group_e grp;
		logic [3:0] settle;
		logic [2:0] bwid;
		logic pu_open;
		logic pl_open;
		logic [3:0] dup;
		logic [7:0] ra;
		logic [7:0] rb;
		logic [7:0] rc;
		logic [7:0] rd;
		exit_e exit_opt;
		logic clutch_n;
		logic [7:0] ref_cnt;
		logic ref_clk;
		logic next_second;
		logic nv_cs_n;
		logic nv_we_n;
		logic fin_cs_n;
	} state_s;

	state_s q, d;
	logic req_ready;
	logic [7:0] byte1;
	logic [7:0] byte2;

	// Option code from return bits {7,4,1}.
	function automatic exit_e decode_exit(input logic [7:0] r);
		exit_e e;
		e = exit_none;
		if (!r[7]) begin
			case ({r[1], r[4]})
				2'h0: e = exit_separator;
				2'h1: e = exit_bridge;
				2'h3: e = exit_offset;
				default: e = exit_none;
			endcase
		end
		return e;
	endfunction : decode_exit

	// --------------------------------------------------------------
	// Drive byte assembly
	// --------------------------------------------------------------
	// Clutch and solenoid inputs are active high requests; the bus bits are
	// active low, so they are inverted here. Unused bits sit low.
	always_comb begin
		if (large_capacity_feeder) begin
			byte1 = {3'h0, ~bulk_pickup, ~bulk_feed_clutch, ~bulk_transport_clutch,
				bulk_low_speed, bulk_motor_on};
			byte2 = {3'h0, ~bulk_fence_solenoid, bulk_fence_motor, bulk_tray};
		end else begin
			byte1 = {1'b0, ~ped_transport_clutch, ~ped_lower_clutch, ~ped_upper_clutch,
				2'h0, ped_motor};
			byte2 = {4'h0, ped_lower_tray, ped_upper_tray};
		end
	end

	// --------------------------------------------------------------
	// Scan, decode and pin sequencing
	// --------------------------------------------------------------
	always_comb begin
		d = q;
		// Sensor and request pins pass two flops before anything looks at them.
		d.sz1 = size_input_bus;
		d.sz2 = q.sz1;
		d.rt1 = return_input_bus;
		d.rt2 = q.rt1;
		d.rq1 = {upper_transport_request, middle_transport_request};
		d.rq2 = q.rq1;
		// Each group is held long enough for buffer and synchroniser delay,
		// then sampled once on the last settle cycle before moving on.
		if (q.settle != 4'h0) begin
			d.settle = q.settle - 4'h1;
		end else begin
			case (q.grp)
				grp_a: begin
					d.bwid = ~q.sz2[2:0];
					d.ra = q.rt2;
					d.exit_opt = decode_exit(q.rt2);
				end
				grp_b: begin
					d.pu_open = q.sz2[0];
					d.rb = q.rt2;
				end
				grp_c: begin
					d.pl_open = q.sz2[0];
					d.rc = q.rt2;
				end
				grp_d: begin
					d.dup = {~q.sz2[3], q.sz2[2:0]};
					d.rd = q.rt2;
				end
				default: d.rd = q.rt2;
			endcase
			d.grp = group_e'(q.grp + 2'h1);
			d.settle = SETTLE_CYC + 4'h2;
		end
		// First low, second high turns the clutch on; both low is off.
		case (q.rq2)
			2'h1: d.clutch_n = 1'b0;
			2'h0: d.clutch_n = 1'b1;
			default: d.clutch_n = q.clutch_n;
		endcase
		// Reference clock toggles at a fixed rate while the motor runs.
		if (!main_motor_run) begin
			d.ref_cnt = 8'h0;
			d.ref_clk = 1'b0;
		end else if (q.ref_cnt >= REF_HALF_CYC - 8'h1) begin
			d.ref_cnt = 8'h0;
			d.ref_clk = ~q.ref_clk;
		end else begin
			d.ref_cnt = q.ref_cnt + 8'h1;
		end
		// Latch bytes are refreshed alternately, so each latch follows its
		// commands within two strobe cycles.
		if (req_ready) begin
			d.next_second = ~q.next_second;
		end
		d.nv_cs_n = ~nvmem_access;
		d.nv_we_n = ~(nvmem_access & nvmem_write);
		d.fin_cs_n = ~(finisher_access & ~nvmem_access);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.clutch_n <= 1'b1;
			q.nv_cs_n <= 1'b1;
			q.nv_we_n <= 1'b1;
			q.fin_cs_n <= 1'b1;
			q.settle <= SETTLE_CYC + 4'h2;
		end else begin
			q <= d;
		end
	end

	// --------------------------------------------------------------
	// Drive sequencer
	// --------------------------------------------------------------
	strobe_drive u_drive (
		.mclk(mclk),
		.rst_b(rst_b),
		.req_valid(1'b1),
		.req_second(q.next_second),
		.req_data(q.next_second ? byte2 : byte1),
		.req_ready(req_ready),
		.drive_output_bus(drive_output_bus),
		.first_feeder_strobe(first_feeder_strobe),
		.second_feeder_strobe(second_feeder_strobe)
	);

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	// Exactly one enable is low, decoded from a single state field.
	assign group_a_enable_n = (q.grp != grp_a);
	assign group_b_enable_n = (q.grp != grp_b);
	assign group_c_enable_n = (q.grp != grp_c);
	assign group_d_enable_n = (q.grp != grp_d);
	assign bypass_width = q.bwid;
	assign ped_upper_drawer_open = q.pu_open;
	assign ped_lower_drawer_open = q.pl_open;
	assign duplex_entry_paper = q.dup[0];
	assign duplex_exit_paper = q.dup[1];
	assign duplex_open = q.dup[2];
	assign duplex_connected = q.dup[3];
	assign ret_group_a = q.ra;
	assign ret_group_b = q.rb;
	assign ret_group_c = q.rc;
	assign ret_group_d = q.rd;
	assign exit_option = q.exit_opt;
	assign upper_transport_clutch_n = q.clutch_n;
	assign main_motor_ref_clock = q.ref_clk;
	assign nvmem_select_n = q.nv_cs_n;
	assign nvmem_write_en_n = q.nv_we_n;
	assign finisher_select_n = q.fin_cs_n;

endmodule : paper_feed_multiplexed_io

`default_nettype wire

/* File: feed_io_sva.sv */
`timescale 1ns/10ps
`default_nettype none

// Pin relations of the feed port block, seen from its ports only.
module feed_io_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Enables, drive bus and strobes
	input wire logic group_a_enable_n,
	input wire logic group_b_enable_n,
	input wire logic group_c_enable_n,
	input wire logic group_d_enable_n,
	input wire logic first_feeder_strobe,
	input wire logic second_feeder_strobe,
	input wire logic [7:0] drive_output_bus,
	// Clutch, reference clock and selects
	input wire logic upper_transport_request,
	input wire logic middle_transport_request,
	input wire logic upper_transport_clutch_n,
	input wire logic main_motor_ref_clock,
	input wire logic nvmem_access,
	input wire logic nvmem_write,
	input wire logic nvmem_select_n,
	input wire logic nvmem_write_en_n
);
	// One domain, so clock and reset are named once.
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_one_enable: assert property (
		$onehot(~{group_a_enable_n, group_b_enable_n, group_c_enable_n, group_d_enable_n}))
		else $error("enable count wrong");
	// Each group is held for seven cycles: six settle counts plus the sample cycle.
	a_scan_hold: assert property (
		$fell(group_b_enable_n) |-> !group_b_enable_n[*7] ##1 !group_c_enable_n)
		else $error("scan hold or order wrong");
	a_strobe_width: assert property (
		$rose(first_feeder_strobe) |-> first_feeder_strobe[*2] ##1 !first_feeder_strobe)
		else $error("strobe width wrong");
	// The latch edge must never see the bus move under it.
	a_bus_steady: assert property (
		first_feeder_strobe || second_feeder_strobe |-> $stable(drive_output_bus))
		else $error("bus moved under strobe");
	a_strobe_turn: assert property (
		$rose(second_feeder_strobe) |-> $past(first_feeder_strobe, 5))
		else $error("strobes out of turn");
	a_clutch_on: assert property (
		(!upper_transport_request && middle_transport_request)[*4] |=> !upper_transport_clutch_n)
		else $error("clutch not on");
	a_nvmem_sel: assert property (
		nvmem_access |=> !nvmem_select_n && nvmem_write_en_n == !$past(nvmem_write))
		else $error("memory select wrong");
	a_ref_half: assert property (
		$rose(main_motor_ref_clock) |-> ##25 !main_motor_ref_clock)
		else $error("reference half period wrong");
endmodule : feed_io_sva

bind paper_feed_multiplexed_io feed_io_sva chk_u (.*);

`default_nettype wire

/* File: feed_latch_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Bus buffers, sensors and the two output latches outside the block.
module feed_latch_model (
	// Pins of the block
	input wire logic [3:0] en_n,
	input wire logic first_feeder_strobe,
	input wire logic second_feeder_strobe,
	input wire logic [7:0] drive_output_bus,
	// Sensor levels per group, group A in the low slice
	input wire logic [15:0] size_v,
	input wire logic [31:0] ret_v,
	// Buffered buses and latched bytes
	output logic [3:0] size_input_bus,
	output logic [7:0] return_input_bus,
	output logic [7:0] byte1_q,
	output logic [7:0] byte2_q
);
	// A released bus shows no stale value, so an unsampled gap cannot pass.
	always_comb begin
		size_input_bus = ~size_v[3:0];
		return_input_bus = ~ret_v[7:0];
		for (int i = 0; i < 4; i++) begin
			if (!en_n[i]) begin
				size_input_bus = size_v[4*i+:4];
				return_input_bus = ret_v[8*i+:8];
			end
		end
	end

	// The latches take the bus on the rising strobe edge only.
	always_ff @(posedge first_feeder_strobe) byte1_q <= drive_output_bus;
	always_ff @(posedge second_feeder_strobe) byte2_q <= drive_output_bus;
endmodule : feed_latch_model

`default_nettype wire

/* File: test_paper_feed_multiplexed_io.sv */
`timescale 1ns/10ps
`default_nettype none

module test_paper_feed_multiplexed_io;
	import feed_io_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, large_capacity_feeder = 1'b0;
	logic [1:0] ped_motor = 2'h0, ped_upper_tray = 2'h0, ped_lower_tray = 2'h0;
	logic ped_upper_clutch = 1'b0, ped_lower_clutch = 1'b0, ped_transport_clutch = 1'b0;
	logic bulk_motor_on = 1'b0, bulk_low_speed = 1'b0, bulk_transport_clutch = 1'b0;
	logic bulk_feed_clutch = 1'b0, bulk_pickup = 1'b0, bulk_fence_solenoid = 1'b0;
	logic [1:0] bulk_tray = 2'h0, bulk_fence_motor = 2'h0, exit_option;
	logic upper_transport_request = 1'b0, middle_transport_request = 1'b0;
	logic main_motor_run = 1'b0, nvmem_access = 1'b0, nvmem_write = 1'b0, finisher_access = 1'b0;
	logic [15:0] size_v = 16'h0000;
	logic [31:0] ret_v = 32'h0000_0000;
	logic [3:0] size_input_bus;
	logic [7:0] return_input_bus, drive_output_bus, byte1_q, byte2_q;
	logic [7:0] ret_group_a, ret_group_b, ret_group_c, ret_group_d;
	logic group_a_enable_n, group_b_enable_n, group_c_enable_n, group_d_enable_n;
	logic first_feeder_strobe, second_feeder_strobe, upper_transport_clutch_n;
	logic main_motor_ref_clock, nvmem_select_n, nvmem_write_en_n, finisher_select_n;
	logic [2:0] bypass_width;
	logic ped_upper_drawer_open, ped_lower_drawer_open, duplex_entry_paper, duplex_exit_paper;
	logic duplex_open, duplex_connected;
	int errors = 0, n_compared = 0;

	paper_feed_multiplexed_io dut_u (.*);
	feed_latch_model far_u (
		.en_n({group_d_enable_n, group_c_enable_n, group_b_enable_n, group_a_enable_n}),
		.*
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	initial forever #50 mclk = ~mclk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Sensors change while the scan runs; 60 cycles cover two full rounds.
	task automatic t_sense(input logic [15:0] s, input logic [31:0] r, input exit_e ex);
		size_v = s;
		ret_v = r;
		tick(60);
		chk(8'(bypass_width), {5'h0, ~s[2:0]}, "width");
		chk(8'({ped_lower_drawer_open, ped_upper_drawer_open}),
			{6'h0, s[8], s[4]}, "drawer");
		chk(8'({duplex_connected, duplex_open, duplex_exit_paper, duplex_entry_paper}),
			{4'h0, ~s[15], s[14:12]}, "duplex");
		chk(ret_group_a, r[7:0], "ret a");
		chk(ret_group_b, r[15:8], "ret b");
		chk(ret_group_c, r[23:16], "ret c");
		chk(ret_group_d, r[31:24], "ret d");
		chk(8'(exit_option), 8'(ex), "exit");
	endtask : t_sense

	// Every motor code of both layouts, with the single bits spread around.
	task automatic t_drive(input logic bulk, input logic [1:0] m);
		large_capacity_feeder = bulk;
		ped_motor = m[0] ? PED_MOTOR_ON : (m[1] ? PED_MOTOR_OFF : PED_MOTOR_BRAKE);
		{ped_upper_tray, ped_lower_tray, bulk_tray, bulk_fence_motor} = {m, ~m, m, ~m};
		{ped_upper_clutch, ped_lower_clutch, ped_transport_clutch} = {m, ^m};
		{bulk_motor_on, bulk_low_speed, bulk_transport_clutch} = {m, ^m};
		{bulk_feed_clutch, bulk_pickup, bulk_fence_solenoid} = {m, ~m[0]};
		tick(30);
		if (bulk) begin
			chk(byte1_q, {3'h0, ~bulk_pickup, ~bulk_feed_clutch, ~bulk_transport_clutch,
				bulk_low_speed, bulk_motor_on}, "bulk byte1");
			chk(byte2_q, {3'h0, ~bulk_fence_solenoid, bulk_fence_motor, bulk_tray},
				"bulk byte2");
		end else begin
			chk(byte1_q, {1'b0, ~ped_transport_clutch, ~ped_lower_clutch, ~ped_upper_clutch,
				2'h0, ped_motor}, "ped byte1");
			chk(byte2_q, {4'h0, ped_lower_tray, ped_upper_tray}, "ped byte2");
		end
	endtask : t_drive

	// Requests walk through on, hold, off, hold, on.
	task automatic t_clutch();
		logic [9:0] seq;
		logic [4:0] exp;
		seq = 10'b01_11_00_10_01;
		exp = 5'b0_0_1_1_0;
		for (int i = 4; i >= 0; i--) begin
			{upper_transport_request, middle_transport_request} = seq[2*i+:2];
			tick(6);
			chk(8'(upper_transport_clutch_n), 8'(exp[i]), "clutch");
		end
	endtask : t_clutch

	// All select combinations; the finisher yields to the memory.
	task automatic t_sel();
		for (int i = 0; i < 8; i++) begin
			{nvmem_access, nvmem_write, finisher_access} = 3'(i);
			tick(2);
			chk(8'(nvmem_select_n), 8'(!i[2]), "mem sel");
			chk(8'(nvmem_write_en_n), 8'(!(i[2] && i[1])), "mem write");
			chk(8'(finisher_select_n), 8'(!(i[0] && !i[2])), "fin sel");
		end
	endtask : t_sel

	// Half period measured in cycles, then the clock must stop low.
	task automatic t_ref();
		int n;
		n = 0;
		main_motor_run = 1'b1;
		while (main_motor_ref_clock !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		// A clock that never rises counts once and hands over to the closing report.
		if (n == 100) begin
			errors++;
			return;
		end
		n = 0;
		while (main_motor_ref_clock === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk(8'(n), 8'(REF_HALF_CYC), "ref half");
		main_motor_run = 1'b0;
		tick(3);
		chk(8'(main_motor_ref_clock), 8'h00, "ref idle");
	endtask : t_ref

	// Main sequence: reset values first, then four sense runs, eight drive runs and the other scenarios once.
	initial begin
		tick(20);
		chk(8'({group_d_enable_n, group_c_enable_n, group_b_enable_n, group_a_enable_n}),
			8'h0e, "reset enables");
		rst_b = 1'b1;
		t_sense(16'h1e05, 32'h81c3_5a00, exit_separator);
		t_sense(16'he1fa, 32'h7e3c_a510, exit_bridge);
		t_sense(16'h7018, 32'h0f5a_c312, exit_offset);
		t_sense(16'h8fe3, 32'hf00f_3c80, exit_none);
		for (int k = 0; k < 8; k++) begin
			t_drive(k[2], 2'(k));
		end
		t_clutch();
		t_sel();
		t_ref();
		finish_test();
	end
endmodule : test_paper_feed_multiplexed_io

`default_nettype wire
